// [verilog/config_memory_crc_checker.v]
// configuration memory crc checker: frame check at load, sweep in user mode
//
// Behaviour
// - crc each incoming frame, compare with carried value
// - load stops on mismatch or after all frames
// - 16-bit check per frame, frame length programmable
// - check bits shift in while crc computed
// - frame mismatch drives status line low
// - whole-stream reference crc stored at load end
// - user mode repeatedly recomputes and compares crc
// - checking stops on reconfig request low or when checking is disabled
// - only configuration cells are swept
// - ieee 802 crc32, one value per sweep
// - zero signature holds error flag low
// - nonzero signature raises error flag
// - error flag open drain, active high
// - flag pin used only when checking enabled
// - access instruction puts reference on scan path
// - instruction works only in user mode
// - checking starts automatically on user mode entry
// - flag holds through next pass, no history
// - checker clock divided by two to the n
// - reference access does not disturb user logic
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`include "cfg_crc_defs.vh"
module config_memory_crc_checker (
  input wire clk_sys_i,
  input wire nrst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output reg [31:0] prdata_o,
  // configuration load stream
  input wire reconfig_request_n_i,
  input wire load_valid_i,
  input wire load_bit_i,
  input wire load_last_frame_i,
  input wire [31:0] load_ref_crc_i,
  input wire load_ref_valid_i,
  output reg cfg_status_n_o,
  output reg cfg_done_o,
  // configuration cell memory sweep port
  output reg [19:0] cell_addr_o,
  output reg cell_rd_o,
  input wire cell_bit_i,
  input wire [19:0] cell_count_i,
  // jtag data register path
  input wire [9:0] jtag_ir_i,
  input wire jtag_capture_i,
  input wire jtag_shift_i,
  input wire jtag_update_i,
  input wire jtag_tdi_i,
  output wire jtag_tdo_o,
  // open-drain error flag
  output wire crc_error_o,
  output wire crc_error_oe_o,
  output wire user_mode_o
);
  localparam ST_LOAD = 2'h0;
  localparam ST_FAIL = 2'h1;
  localparam ST_USER = 2'h2;

  reg [1:0] state_reg;
  reg [31:0] ctrl_reg;
  reg [15:0] frame_len_reg;
  reg [15:0] bit_cnt_reg;
  reg [15:0] frame_cnt_reg;
  reg [31:0] ref_reg;
  reg [31:0] jtag_sr_reg;
  reg err_flag_reg;
  reg pass_done_reg;
  reg [7:0] div_cnt_reg;
  reg div_tick;
  reg sweeping_reg;
  reg rd_pend_reg;
  reg last_bit_pend_reg;
  wire check_en;
  wire [3:0] div_sel;
  wire in_check;
  wire last_check;
  wire frame_mismatch;
  wire frame_ok;
  wire [31:0] sig;
  wire sig_done;
  wire apb_wr;
  wire ref_instr;
  wire [3:0] div_eff;
  wire [15:0] div_load;

  assign check_en = ctrl_reg[`CTRL_CHECK_EN];
  assign div_sel = ctrl_reg[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
  // larger codes clamp to the slowest documented divisor
  assign div_eff = (div_sel > `DIV_MAX) ? `DIV_MAX : div_sel;
  // reload is 2^n - 1; computed wide so n = 8 does not wrap before the cut
  assign div_load = (16'h0001 << div_eff) - 16'h0001;
  assign user_mode_o = (state_reg == ST_USER);
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // frame bit position: data bits then 16 check bits
  assign in_check = (bit_cnt_reg >= frame_len_reg);
  assign last_check = (bit_cnt_reg == frame_len_reg + 16'h000F);

  crc_frame_check u_frame (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .clear_i(!reconfig_request_n_i),
    .data_valid_i(load_valid_i && state_reg == ST_LOAD),
    .data_bit_i(load_bit_i),
    .is_check_i(in_check),
    .last_check_i(last_check),
    .mismatch_o(frame_mismatch),
    .frame_ok_o(frame_ok)
  );

  // bit and frame counting during load
  always @(posedge clk_sys_i) begin
    if (!nrst_i || !reconfig_request_n_i) begin
      bit_cnt_reg <= 16'h0000;
      frame_cnt_reg <= 16'h0000;
    end else if (state_reg == ST_LOAD && load_valid_i) begin
      if (last_check) begin
        bit_cnt_reg <= 16'h0000;
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 16'h0001;
      end
    end
  end

  // load / fail / user sequencing; reconfig request returns to load
  always @(posedge clk_sys_i) begin
    if (!nrst_i || !reconfig_request_n_i) begin
      state_reg <= ST_LOAD;
      cfg_status_n_o <= 1'b1;
      cfg_done_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          if (frame_mismatch) begin
            state_reg <= ST_FAIL;
            cfg_status_n_o <= 1'b0;
          end else if (frame_ok && load_last_frame_i) begin
            state_reg <= ST_USER;
            cfg_done_o <= 1'b1;
          end
        end
        ST_FAIL: begin
          cfg_status_n_o <= 1'b0;
        end
        ST_USER: begin
          cfg_done_o <= 1'b1;
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  // jtag reference access: only in user mode, never stalls the sweep
  assign ref_instr = (jtag_ir_i == `REF_ACCESS_INSTR) && user_mode_o;
  assign jtag_tdo_o = jtag_sr_reg[0];

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      jtag_sr_reg <= 32'h0000_0000;
    end else if (ref_instr && jtag_capture_i) begin
      jtag_sr_reg <= ref_reg;
    end else if (ref_instr && jtag_shift_i) begin
      jtag_sr_reg <= {jtag_tdi_i, jtag_sr_reg[31:1]};
    end
  end

  // reference storage: loaded whenever load_ref_valid_i is high during configuration, replaced by jtag update
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ref_reg <= 32'h0000_0000;
    end else if (state_reg == ST_LOAD && load_ref_valid_i) begin
      ref_reg <= load_ref_crc_i;
    end else if (ref_instr && jtag_update_i) begin
      ref_reg <= jtag_sr_reg;
    end
  end

  // checker clock enable: system clock divided by 2^n
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_cnt_reg <= 8'h00;
      div_tick <= 1'b0;
    end else begin
      div_tick <= (div_cnt_reg == 8'h00);
      if (div_cnt_reg == 8'h00) begin
        div_cnt_reg <= div_load[7:0];
      end else begin
        div_cnt_reg <= div_cnt_reg - 8'h01;
      end
    end
  end

  // sweep address walk over configuration cells only
  always @(posedge clk_sys_i) begin
    if (!nrst_i || !user_mode_o || !check_en) begin
      sweeping_reg <= 1'b0;
      cell_addr_o <= 20'h00000;
      cell_rd_o <= 1'b0;
      rd_pend_reg <= 1'b0;
      last_bit_pend_reg <= 1'b0;
    end else begin
      cell_rd_o <= 1'b0;
      rd_pend_reg <= cell_rd_o;
      last_bit_pend_reg <= 1'b0;
      if (!sweeping_reg) begin
        sweeping_reg <= 1'b1;
        cell_addr_o <= 20'h00000;
      end else if (div_tick && !cell_rd_o && !rd_pend_reg && !last_bit_pend_reg) begin
        cell_rd_o <= 1'b1;
      end else if (rd_pend_reg) begin
        if (cell_addr_o == cell_count_i - 20'h00001) begin
          cell_addr_o <= 20'h00000;
          last_bit_pend_reg <= 1'b1;
        end else begin
          cell_addr_o <= cell_addr_o + 20'h00001;
        end
      end
    end
  end

  crc32_engine u_crc (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(!sweeping_reg || sig_done),
    .bit_en_i(rd_pend_reg),
    .data_bit_i(cell_bit_i),
    .finish_i(last_bit_pend_reg),
    .ref_i(ref_reg),
    .sig_o(sig),
    .done_o(sig_done)
  );

  // flag changes only at pass end or when checking stops; no history between passes
  always @(posedge clk_sys_i) begin
    if (!nrst_i || !user_mode_o || !check_en) begin
      err_flag_reg <= 1'b0;
      pass_done_reg <= 1'b0;
    end else if (sig_done) begin
      err_flag_reg <= (sig != 32'h0000_0000);
      pass_done_reg <= 1'b1;
    end
  end

  // open drain: drive low for no error, release for error
  assign crc_error_o = 1'b0;
  assign crc_error_oe_o = check_en && !err_flag_reg;

  // apb write path
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ctrl_reg <= `CTRL_RESET;
      frame_len_reg <= `FRAME_LEN_RESET;
    end else if (apb_wr && paddr_i == `ADDR_CTRL) begin
      ctrl_reg <= {24'h000000, pwdata_i[7:4], 3'h0, pwdata_i[0]};
    end else if (apb_wr && paddr_i == `ADDR_FRAME_LEN) begin
      frame_len_reg <= pwdata_i[15:0];
    end
  end

  // apb read path, unmapped reads zero
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        `ADDR_CTRL: prdata_o <= ctrl_reg;
        `ADDR_STATUS: prdata_o <= {27'h0000000, pass_done_reg, err_flag_reg,
          cfg_done_o, !cfg_status_n_o, user_mode_o};
        `ADDR_REF: prdata_o <= ref_reg;
        `ADDR_SIG: prdata_o <= sig;
        `ADDR_FRAME_LEN: prdata_o <= {16'h0000, frame_len_reg};
        `ADDR_FRAME_CNT: prdata_o <= {16'h0000, frame_cnt_reg};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// [verilog/cfg_crc_defs.vh]
// shared constants for the configuration memory crc checker
`ifndef CFG_CRC_DEFS_VH
`define CFG_CRC_DEFS_VH
// apb register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_REF 12'h008
`define ADDR_SIG 12'h00C
`define ADDR_FRAME_LEN 12'h010
`define ADDR_FRAME_CNT 12'h014
// control register fields
`define CTRL_CHECK_EN 0
`define CTRL_DIV_LSB 4
`define CTRL_DIV_MSB 7
// status register fields
`define ST_USER_MODE 0
`define ST_CFG_ERR 1
`define ST_CFG_DONE 2
`define ST_CRC_ERR 3
`define ST_PASS_DONE 4
// reset values
`define CTRL_RESET 32'h0000_0000
`define FRAME_LEN_RESET 16'h0010
// crc polynomials
`define POLY32 32'h04C11DB7
`define POLY16 16'h8005
// jtag instruction for reference register access
`define REF_ACCESS_INSTR 10'h015
`define DIV_MAX 4'h8
`endif

// [verilog/crc_frame_check.v]
// 16-bit per-frame crc computation and compare during loading
`include "cfg_crc_defs.vh"
module crc_frame_check (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire clear_i,
  input wire data_valid_i,
  input wire data_bit_i,
  input wire is_check_i,
  input wire last_check_i,
  output reg mismatch_o,
  output reg frame_ok_o
);
  reg [15:0] crc_reg;
  reg [15:0] crc_next;
  reg [15:0] rx_reg;
  reg [15:0] rx_next;
  reg fb;

  // data bits feed the crc; check bits feed the received shifter in parallel
  always @* begin
    crc_next = crc_reg;
    rx_next = rx_reg;
    fb = crc_reg[15] ^ data_bit_i;
    if (data_valid_i && !is_check_i) begin
      crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? `POLY16 : 16'h0000);
    end
    if (data_valid_i && is_check_i) begin
      rx_next = {rx_reg[14:0], data_bit_i};
    end
  end

  // compare once the last check bit has arrived
  always @(posedge clk_sys_i) begin
    if (!nrst_i || clear_i) begin
      crc_reg <= 16'h0000;
      rx_reg <= 16'h0000;
      mismatch_o <= 1'b0;
      frame_ok_o <= 1'b0;
    end else begin
      mismatch_o <= 1'b0;
      frame_ok_o <= 1'b0;
      crc_reg <= crc_next;
      rx_reg <= rx_next;
      if (data_valid_i && is_check_i && last_check_i) begin
        crc_reg <= 16'h0000;
        rx_reg <= 16'h0000;
        if (rx_next != crc_reg) begin
          mismatch_o <= 1'b1;
        end else begin
          frame_ok_o <= 1'b1;
        end
      end
    end
  end
endmodule

// [verilog/crc32_engine.v]
// serial 32-bit crc over the cell stream, folded with the reference
`include "cfg_crc_defs.vh"
module crc32_engine (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire start_i,
  input wire bit_en_i,
  input wire data_bit_i,
  input wire finish_i,
  input wire [31:0] ref_i,
  output reg [31:0] sig_o,
  output reg done_o
);
  reg [31:0] crc_reg;
  wire fb;

  assign fb = crc_reg[31] ^ data_bit_i;

  // signature is computed crc xor stored reference: zero when intact
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      crc_reg <= 32'hFFFF_FFFF;
      sig_o <= 32'h0000_0000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        crc_reg <= 32'hFFFF_FFFF;
      end else if (finish_i) begin
        sig_o <= ~crc_reg ^ ref_i;
        done_o <= 1'b1;
      end else if (bit_en_i) begin
        crc_reg <= {crc_reg[30:0], 1'b0} ^ (fb ? `POLY32 : 32'h0000_0000);
      end
    end
  end
endmodule

// [bench/config_memory_crc_checker_asserts.sv]
// pin-level assertions for the configuration memory crc checker
module config_memory_crc_checker_asserts (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reconfig_request_n_i,
  input wire logic cfg_status_n_o,
  input wire logic cfg_done_o,
  input wire logic user_mode_o,
  input wire logic [19:0] cell_addr_o,
  input wire logic cell_rd_o,
  input wire logic [19:0] cell_count_i,
  input wire logic crc_error_o,
  input wire logic crc_error_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // open drain: the pad may only ever be pulled low
  chk_pull_low_only: assert property (crc_error_oe_o |-> !crc_error_o)
    else $error("flag pad driven high");
  chk_fail_no_done: assert property (!cfg_status_n_o |-> !cfg_done_o)
    else $error("load completed after frame mismatch");
  chk_fail_in_load: assert property ($fell(cfg_status_n_o) |-> !$past(user_mode_o))
    else $error("status line fell outside loading");
  chk_reconfig_stop: assert property (!reconfig_request_n_i |=> !user_mode_o)
    else $error("checking ran on under reconfig request");
  chk_done_follows: assert property ($rose(user_mode_o) |-> ##[0:1] cfg_done_o)
    else $error("done missing on user mode entry");
  chk_sweep_starts: assert property ($rose(user_mode_o) |-> ##[1:300] cell_rd_o)
    else $error("sweep did not start");
  chk_sweep_range: assert property (cell_rd_o |-> cell_addr_o < cell_count_i)
    else $error("sweep read beyond cell range");
  chk_no_load_sweep: assert property (!user_mode_o && !$past(user_mode_o) |-> !cell_rd_o)
    else $error("sweep read while loading");
  // main scenarios reached
  cover property ($rose(user_mode_o));
  cover property ($fell(cfg_status_n_o));
  cover property (user_mode_o && $fell(crc_error_oe_o));
  cover property (user_mode_o && $rose(crc_error_oe_o));
endmodule

bind config_memory_crc_checker config_memory_crc_checker_asserts config_memory_crc_checker_asserts_i (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reconfig_request_n_i(reconfig_request_n_i),
  .cfg_status_n_o(cfg_status_n_o), .cfg_done_o(cfg_done_o), .user_mode_o(user_mode_o),
  .cell_addr_o(cell_addr_o), .cell_rd_o(cell_rd_o), .cell_count_i(cell_count_i),
  .crc_error_o(crc_error_o), .crc_error_oe_o(crc_error_oe_o)
);

// [bench/cell_memory_model.sv]
// behavioural configuration cell memory answering sweep reads
module cell_memory_model #(
  parameter logic [63:0] CELLS = 64'h0
) (
  input wire logic clk_sys_i,
  input wire logic [19:0] cell_addr_i,
  input wire logic cell_rd_i,
  output logic cell_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cell_bit_o = 1'b0;
  // only configuration cells answer; between reads the line toggles
  // so a late sample never sees a stale but lucky bit
  always @(posedge clk_sys_i) begin
    if (cell_rd_i) cell_bit_o <= CELLS[cell_addr_i[5:0]];
    else cell_bit_o <= ~cell_bit_o;
  end
endmodule

// [bench/tb_config_memory_crc_checker.sv]
// self-checking bench for the configuration memory crc checker
`include "cfg_crc_defs.vh"
module tb_config_memory_crc_checker;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] CELLS = 64'hC3A5_0F96_1E2D_7B48;
  localparam int NCELL = 48;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rcfg_n = 1'b1;
  logic lval = 1'b0, lbit = 1'b0, llast = 1'b0, lrefv = 1'b0;
  logic cap = 1'b0, shf = 1'b0, upd = 1'b0, tdi = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [9:0] ir = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, lref = 32'h0000_0000, good, bad, r, old;
  wire logic pready, perr, status_n, done, crd, cbit, tdo, err, err_oe, umode;
  wire logic [31:0] prdata;
  wire logic [19:0] caddr;
  int errors = 0, check_count = 0;
  // open-drain pad with its external pull-up
  wire logic pin = err_oe ? err : 1'b1;

  initial forever #2 clk = ~clk;

  config_memory_crc_checker config_memory_crc_checker_i (
    .clk_sys_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(perr), .prdata_o(prdata),
    .reconfig_request_n_i(rcfg_n), .load_valid_i(lval), .load_bit_i(lbit),
    .load_last_frame_i(llast), .load_ref_crc_i(lref), .load_ref_valid_i(lrefv),
    .cfg_status_n_o(status_n), .cfg_done_o(done), .cell_addr_o(caddr), .cell_rd_o(crd),
    .cell_bit_i(cbit), .cell_count_i(20'h00030), .jtag_ir_i(ir), .jtag_capture_i(cap),
    .jtag_shift_i(shf), .jtag_update_i(upd), .jtag_tdi_i(tdi), .jtag_tdo_o(tdo),
    .crc_error_o(err), .crc_error_oe_o(err_oe), .user_mode_o(umode)
  );
  cell_memory_model #(.CELLS(CELLS)) cell_memory_model_i (
    .clk_sys_i(clk), .cell_addr_i(caddr), .cell_rd_i(crd), .cell_bit_o(cbit)
  );

  task automatic conclude();
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // msb-first frame crc, zero start
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c = 16'h0000;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `POLY16 : 16'h0000);
    return c;
  endfunction

  // stored reference is the inverted sweep crc, so a clean pass gives zero
  function automatic logic [31:0] cell_crc();
    logic [31:0] c = 32'hFFFF_FFFF;
    for (int i = 0; i < NCELL; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ CELLS[i]) ? `POLY32 : 32'h0000_0000);
    return ~c;
  endfunction

  // waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(r, exp);
  endtask

  // capture, shift 32 bits lsb first reading the old value, update
  task automatic jtag(input logic [31:0] nv);
    @(posedge clk);
    ir <= `REF_ACCESS_INSTR;
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    shf <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      tdi <= nv[i];
      @(negedge clk);
      old[i] = tdo;
      @(posedge clk);
    end
    shf <= 1'b0;
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask

  // sixteen data bits then check bits, optionally corrupted
  task automatic frame(input logic [15:0] d, input logic flip, input logic last);
    logic [31:0] s;
    s = {d, crc16(d) ^ {15'h0000, flip}};
    @(posedge clk);
    llast <= last;
    for (int i = 31; i >= 0; i--) begin
      lval <= 1'b1;
      lbit <= s[i];
      @(posedge clk);
    end
    lval <= 1'b0;
  endtask

  task automatic wait_pin(input logic v);
    @(negedge clk);
    for (int n = 0; n < 4000 && pin !== v; n++) @(negedge clk);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    good = cell_crc();
    bad = good ^ 32'h0000_0100;
    rd(`ADDR_CTRL, `CTRL_RESET);
    rd(`ADDR_FRAME_LEN, 32'h0000_0010);
    rd(12'h0FC, 32'h0000_0000);
    check(perr, 1'b0);
    check(pin, 1'b1);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
    rd(`ADDR_CTRL, 32'h0000_0001);
    lref <= good;
    lrefv <= 1'b1;
    frame(16'hA5C3, 1'b0, 1'b0);
    frame(16'h3C5A, 1'b0, 1'b1);
    for (int n = 0; n < 200 && umode !== 1'b1; n++) @(negedge clk);
    check(umode, 1'b1);
    check(status_n, 1'b1);
    rd(`ADDR_REF, good);
    lrefv <= 1'b0;
    wait_pin(1'b0);
    check(pin, 1'b0);
    rd(`ADDR_SIG, 32'h0000_0000);
    jtag(bad);
    check(old, good);
    wait_pin(1'b1);
    check(pin, 1'b1);
    rd(`ADDR_SIG, good ^ bad);
    rd(`ADDR_REF, bad);
    jtag(good);
    check(old, bad);
    wait_pin(1'b0);
    check(pin, 1'b0);
    @(posedge clk);
    rcfg_n <= 1'b0;
    @(posedge clk);
    rcfg_n <= 1'b1;
    @(negedge clk);
    check(umode, 1'b0);
    jtag(bad);
    rd(`ADDR_REF, good);
    frame(16'h1234, 1'b1, 1'b0);
    for (int n = 0; n < 50 && status_n !== 1'b0; n++) @(negedge clk);
    check(status_n, 1'b0);
    check(done, 1'b0);
    conclude();
  end

  // hang guard: the sequence needs only a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule
